// ==== src/ptcd_regs.vh ====
// Purpose: constants for the pack topology configuration decode
// Assumes: 16-bit register, 100 MHz core clock
// Notes: included by all design files
`ifndef PTCD_REGS_VH
`define PTCD_REGS_VH
`define PTCD_ADDR          8'h18
`define PTCD_RESET_VAL     16'hefff
`define PTCD_WMASK         16'hefff
`define PTCD_EN_B_BIT      15
`define PTCD_EN_A_BIT      14
`define PTCD_SCAN_BIT      13
`define PTCD_BLK_HI        11
`define PTCD_BLK_LO        8
`define PTCD_SEL_B_HI      7
`define PTCD_SEL_B_LO      4
`define PTCD_SEL_A_HI      3
`define PTCD_SEL_A_LO      0
`define PTCD_SEL_OFF       4'hf
`define PTCD_SEL_MIN       4'h8
`define PTCD_SEL_MAX       4'he
`define PTCD_SETTLE_NS     30000
`define PTCD_CLK_NS        10
`define PTCD_SETTLE_CYC    ((`PTCD_SETTLE_NS + `PTCD_CLK_NS - 1) / `PTCD_CLK_NS)
// last count of the settle: settle cycles minus one, at counter width
`define PTCD_SETTLE_LAST   12'hbb7
`define PTCD_CNT_W         12
`endif

// ==== src/ptcd_valid_sel.v ====
// Purpose: range check of a four-bit channel selection
// Assumes: valid range is inclusive
// Notes: purely combinational
`timescale 1ns/100ps
`include "ptcd_regs.vh"
module ptcd_valid_sel (
    input  wire [3:0] sel,
    output wire       in_range
);
    assign in_range = (sel >= `PTCD_SEL_MIN) && (sel <= `PTCD_SEL_MAX);
endmodule // ptcd_valid_sel

// ==== src/ptcd_settle_timer.v ====
// Purpose: settling delay counter for alternate-mux scans
// Assumes: start is a one-cycle pulse
// Notes: done pulses once the count expires; bypass gives done at once
`timescale 1ns/100ps
`include "ptcd_regs.vh"
module ptcd_settle_timer (
    input  wire clk,
    input  wire reset,
    input  wire start,
    input  wire use_delay,
    output reg  busy,
    output reg  done
);
    reg [`PTCD_CNT_W-1:0] count_reg;
    localparam [`PTCD_CNT_W-1:0] LAST = `PTCD_SETTLE_LAST;
    always @(posedge clk) begin
        if (reset) begin
            count_reg <= {`PTCD_CNT_W{1'b0}};
            busy      <= 1'b0;
            done      <= 1'b0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                if (use_delay) begin
                    busy      <= 1'b1;
                    count_reg <= {`PTCD_CNT_W{1'b0}};
                end else begin
                    done <= 1'b1;
                end
            end else if (busy) begin
                if (count_reg == LAST) begin
                    busy <= 1'b0;
                    done <= 1'b1;
                end else begin
                    count_reg <= count_reg + {{(`PTCD_CNT_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // ptcd_settle_timer

// ==== src/ptcd_top.v ====
// Purpose: pack topology configuration register and its decode
// Assumes: register written through a decoded write port from the serial link
// Notes: outputs registered, valid one cycle after a write
//        copy A drives the channel decode once both top-cell copies agree
//        a disagreeing enable pair reads as enabled with the supply mux off
//        the settle request is qualified from the stored fields, not the outputs
`timescale 1ns/100ps
`include "ptcd_regs.vh"
// Function
// - top-cell selection valid only when both four-bit copies are identical
// - copies differ: no alert masking, supply-input mux forced off
// - enabled with agreed 0x8..0xE: connect balance switch input 8..14 to supply pin
// - values 0x0..0x7 or 0xF: individual switches off, common switch on
// - top-cell fields reset to 0xF, no masking, mux off
// - agreed top cell always masks alerts above it, any encoding, any enable
// - top-block field picks divider cell input; 0xF selects dedicated block pin
// - top-block 0x0..0x7 treated as 0xF
// - effective enable 0 ignores top block, block pin selected
// - scan bit set: wait 30 us before sampling top cell in alternate-mux scans
// - delay only with enable, agreed valid top cell and alternate-mux select 1
// - bit 14 redundant enable copy, resets to 1, checked against bit 15
// - enable copies differ: effective enable 1 and supply mux forced off
module ptcd_top (
    input  wire        clk,
    input  wire        reset,
    input  wire [7:0]  reg_addr,
    input  wire        reg_wr,
    input  wire [15:0] reg_wdata,
    output reg  [15:0] reg_rdata,
    input  wire        alternate_mux_select,
    input  wire        scan_sample_req,
    output wire        scan_settling,
    output wire        scan_sample_go,
    output reg  [14:0] supply_input_mux,
    output reg         supply_input_common,
    output reg  [14:0] balance_switch_diag_alert_mask,
    output reg  [14:0] block_divider_sel,
    output reg         block_voltage_port_sel,
    output reg         flex_pack_en_eff,
    output reg         top_channel_agree
);
    // stored configuration
    reg  [15:0] cfg_reg;
    reg  [15:0] cfg_next;
    reg  [15:0] rdata_next;
    wire        cfg_hit;
    wire        wr_take;

    // field views of the stored word
    wire [3:0]  top_channel_sel_a;
    wire [3:0]  top_channel_sel_b;
    wire [3:0]  block_tap_sel;
    wire        flex_pack_en_a;
    wire        flex_pack_en_b;
    wire        flex_scan_settle_en;

    // range check results
    wire        cell_ok;
    wire        blk_ok;

    // redundancy checks and effective values
    reg         agree_next;
    reg         en_agree;
    reg         en_eff_next;
    reg         mux_on_next;
    reg         common_next;
    reg         blk_pin_next;
    reg         use_delay;

    // decode vectors span channels 0 to 14
    localparam  CH_COUNT = 15;

    // per-channel decode results
    reg  [14:0] mux_next;
    reg  [14:0] mask_next;
    reg  [14:0] blk_next;
    genvar      i;

    // address decode
    assign cfg_hit             = (reg_addr == `PTCD_ADDR);
    assign wr_take             = reg_wr && cfg_hit;

    // fields of the stored word
    assign top_channel_sel_a   = cfg_reg[`PTCD_SEL_A_HI:`PTCD_SEL_A_LO];
    assign top_channel_sel_b   = cfg_reg[`PTCD_SEL_B_HI:`PTCD_SEL_B_LO];
    assign block_tap_sel       = cfg_reg[`PTCD_BLK_HI:`PTCD_BLK_LO];
    assign flex_pack_en_a      = cfg_reg[`PTCD_EN_A_BIT];
    assign flex_pack_en_b      = cfg_reg[`PTCD_EN_B_BIT];
    assign flex_scan_settle_en = cfg_reg[`PTCD_SCAN_BIT];

    // range checks of the cell and block selections
    ptcd_valid_sel u_cell_chk (
        .sel      (top_channel_sel_a),
        .in_range (cell_ok)
    );

    ptcd_valid_sel u_blk_chk (
        .sel      (block_tap_sel),
        .in_range (blk_ok)
    );

    // the two top-cell copies must match before the selection is trusted
    always @* begin
        if (top_channel_sel_a == top_channel_sel_b) begin
            agree_next = 1'b1;
        end else begin
            agree_next = 1'b0;
        end
    end

    // enable copies: a disagreement reads as enabled
    always @* begin
        if (flex_pack_en_a == flex_pack_en_b) begin
            en_agree    = 1'b1;
            en_eff_next = flex_pack_en_a;
        end else begin
            en_agree    = 1'b0;
            en_eff_next = 1'b1;
        end
    end

    // supply-input mux closes only for an agreed, enabled, supported top cell
    always @* begin
        if (!agree_next) begin
            mux_on_next = 1'b0;
        end else if (!en_agree) begin
            mux_on_next = 1'b0;
        end else if (en_eff_next && cell_ok) begin
            mux_on_next = 1'b1;
        end else begin
            mux_on_next = 1'b0;
        end
    end

    // common switch closes whenever no select switch does
    always @* begin
        if (mux_on_next) begin
            common_next = 1'b0;
        end else begin
            common_next = 1'b1;
        end
    end

    // block divider falls back to the dedicated pin unless enabled and supported
    always @* begin
        if (!en_eff_next) begin
            blk_pin_next = 1'b1;
        end else if (blk_ok) begin
            blk_pin_next = 1'b0;
        end else begin
            blk_pin_next = 1'b1;
        end
    end

    // settling delay only on the supported flexible-pack path
    always @* begin
        if (flex_scan_settle_en && alternate_mux_select) begin
            use_delay = en_eff_next && agree_next && cell_ok;
        end else begin
            use_delay = 1'b0;
        end
    end

    // per-channel decode
    generate
        for (i = 0; i < CH_COUNT; i = i + 1) begin : g_ch
            // balance switch input i to the supply-input pin
            always @* begin
                if (mux_on_next && top_channel_sel_a == i) begin
                    mux_next[i] = 1'b1;
                end else begin
                    mux_next[i] = 1'b0;
                end
            end

            // alerts of channels above the agreed top cell are masked
            always @* begin
                if (agree_next && i > top_channel_sel_a) begin
                    mask_next[i] = 1'b1;
                end else begin
                    mask_next[i] = 1'b0;
                end
            end

            // cell input i to the block divider
            always @* begin
                if (!blk_pin_next && block_tap_sel == i) begin
                    blk_next[i] = 1'b1;
                end else begin
                    blk_next[i] = 1'b0;
                end
            end
        end
    endgenerate

    // register write: only the configuration address is taken, bit 12 stays 0
    always @* begin
        if (wr_take) begin
            cfg_next = reg_wdata & `PTCD_WMASK;
        end else begin
            cfg_next = cfg_reg;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            cfg_reg <= `PTCD_RESET_VAL;
        end else begin
            cfg_reg <= cfg_next;
        end
    end

    // read back: the stored word while addressed, zero otherwise
    always @* begin
        if (cfg_hit) begin
            rdata_next = cfg_reg;
        end else begin
            rdata_next = 16'h0000;
        end
    end

    always @(posedge clk) begin
        if (reset) begin
            reg_rdata <= 16'h0000;
        end else begin
            reg_rdata <= rdata_next;
        end
    end

    // supply-input mux select switches
    always @(posedge clk) begin
        if (reset) begin
            supply_input_mux <= 15'h0000;
        end else begin
            supply_input_mux <= mux_next;
        end
    end

    // common switch, the off state
    always @(posedge clk) begin
        if (reset) begin
            supply_input_common <= 1'b1;
        end else begin
            supply_input_common <= common_next;
        end
    end

    // balance switch alert masking
    always @(posedge clk) begin
        if (reset) begin
            balance_switch_diag_alert_mask <= 15'h0000;
        end else begin
            balance_switch_diag_alert_mask <= mask_next;
        end
    end

    // block divider cell input
    always @(posedge clk) begin
        if (reset) begin
            block_divider_sel <= 15'h0000;
        end else begin
            block_divider_sel <= blk_next;
        end
    end

    // dedicated block pin
    always @(posedge clk) begin
        if (reset) begin
            block_voltage_port_sel <= 1'b1;
        end else begin
            block_voltage_port_sel <= blk_pin_next;
        end
    end

    // effective flexible-pack enable
    always @(posedge clk) begin
        if (reset) begin
            flex_pack_en_eff <= 1'b1;
        end else begin
            flex_pack_en_eff <= en_eff_next;
        end
    end

    // top-cell copies agree
    always @(posedge clk) begin
        if (reset) begin
            top_channel_agree <= 1'b1;
        end else begin
            top_channel_agree <= agree_next;
        end
    end

    // alternate-mux scan settling
    // a request is taken only while the timer is idle
    ptcd_settle_timer u_settle (
        .clk       (clk),
        .reset     (reset),
        .start     (scan_sample_req),
        .use_delay (use_delay),
        .busy      (scan_settling),
        .done      (scan_sample_go)
    );
endmodule // ptcd_top

// ==== bench/ptcd_top_chk.sv ====
// Purpose: assertions on the pack topology decode outputs
// Assumes: settle count of 3000 core cycles
// Notes: bound to ptcd_top from the bench top file
`timescale 1ns/100ps
module ptcd_chk (
    input wire        clk,
    input wire        reset,
    input wire        scan_sample_req,
    input wire        scan_settling,
    input wire        scan_sample_go,
    input wire [14:0] supply_input_mux,
    input wire        supply_input_common,
    input wire [14:0] balance_switch_diag_alert_mask,
    input wire [14:0] block_divider_sel,
    input wire        block_voltage_port_sel,
    input wire        flex_pack_en_eff,
    input wire        top_channel_agree
);
    reg [11:0] cnt_reg;
    always @(posedge clk) begin
        cnt_reg <= (reset || !scan_settling) ? 12'h0 : cnt_reg + 12'h1;
    end
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    mux_common_a: assert property (supply_input_common == (supply_input_mux == 15'h0))
        else $error("common switch wrong");
    mux_range_a: assert property ($onehot0(supply_input_mux) && supply_input_mux[7:0] == 8'h0)
        else $error("supply mux out of range");
    copy_off_a: assert property (!top_channel_agree |-> supply_input_mux == 15'h0 && balance_switch_diag_alert_mask == 15'h0)
        else $error("mismatch not off");
    enable_off_a: assert property (!flex_pack_en_eff |-> supply_input_mux == 15'h0 && block_divider_sel == 15'h0)
        else $error("disabled not off");
    block_pin_a: assert property (block_voltage_port_sel == (block_divider_sel == 15'h0) && $onehot0(block_divider_sel) && block_divider_sel[7:0] == 8'h0)
        else $error("block tap wrong");
    mask_above_a: assert property (supply_input_mux != 15'h0 |-> balance_switch_diag_alert_mask == (~supply_input_mux & ~(supply_input_mux - 15'h1)))
        else $error("alert mask wrong");
    settle_len_a: assert property ($fell(scan_settling) |-> scan_sample_go && cnt_reg == 12'hbb8)
        else $error("settle length wrong");
    settle_start_a: assert property ($rose(scan_settling) |-> $past(scan_sample_req) && !scan_sample_go)
        else $error("settle start wrong");
endmodule // ptcd_chk

// ==== bench/ptcd_top_tb.sv ====
// Purpose: self-checking bench for the pack topology decode
// Assumes: 100 MHz clock, reset held three cycles
// Notes: one scenario moves the address off the config register
`timescale 1ns/100ps
module ptcd_top_tb;
    reg         clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, alternate_mux_select = 1'b0, scan_sample_req = 1'b0;
    reg  [7:0]  reg_addr = 8'h18;
    reg  [15:0] reg_wdata = 16'h0;
    wire [15:0] reg_rdata;
    wire [14:0] supply_input_mux, balance_switch_diag_alert_mask, block_divider_sel;
    wire        scan_settling, scan_sample_go, supply_input_common, block_voltage_port_sel;
    wire        flex_pack_en_eff, top_channel_agree;
    integer     mismatches = 0, comparisons = 0, i, n;
    always #5 clk = ~clk;
    ptcd_top dut_u (
        .clk                            (clk),
        .reset                          (reset),
        .reg_addr                       (reg_addr),
        .reg_wr                         (reg_wr),
        .reg_wdata                      (reg_wdata),
        .reg_rdata                      (reg_rdata),
        .alternate_mux_select           (alternate_mux_select),
        .scan_sample_req                (scan_sample_req),
        .scan_settling                  (scan_settling),
        .scan_sample_go                 (scan_sample_go),
        .supply_input_mux               (supply_input_mux),
        .supply_input_common            (supply_input_common),
        .balance_switch_diag_alert_mask (balance_switch_diag_alert_mask),
        .block_divider_sel              (block_divider_sel),
        .block_voltage_port_sel         (block_voltage_port_sel),
        .flex_pack_en_eff               (flex_pack_en_eff),
        .top_channel_agree              (top_channel_agree)
    );
    task chk(input [63:0] s, input [47:0] g, e);
        comparisons = comparisons + 1;
        if (g !== e) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED %0s expected %h seen %h", s, e, g);
        end
    endtask
    task wr(input [15:0] v);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
    endtask
    task t_reset;
        chk("rdata", reg_rdata, 48'hefff);
        chk("flags", {supply_input_common, block_voltage_port_sel, flex_pack_en_eff, top_channel_agree, supply_input_mux, balance_switch_diag_alert_mask}, 48'hf << 30);
    endtask
    task t_cells;
        for (i = 0; i < 16; i = i + 1) begin
            wr({4'hd, 4'hf, i[3:0], i[3:0]});
            chk("rdata", reg_rdata, {4'hc, 4'hf, i[3:0], i[3:0]});
            chk("mux", {supply_input_common, supply_input_mux}, (i > 7 && i < 15) ? 48'h1 << i : 48'h8000);
            chk("mask", balance_switch_diag_alert_mask, (48'h7fff << (i + 1)) & 48'h7fff);
        end
    endtask
    task t_blocks;
        for (i = 0; i < 16; i = i + 1) begin
            wr({4'hc, i[3:0], 8'hff});
            chk("tap", {block_voltage_port_sel, block_divider_sel}, (i > 7 && i < 15) ? 48'h1 << i : 48'h8000);
        end
    endtask
    task t_mismatch;
        wr(16'hcfa9);
        chk("copies", {top_channel_agree, supply_input_common, supply_input_mux, balance_switch_diag_alert_mask}, 48'h40000000);
        wr(16'h8f99);
        chk("enable", {flex_pack_en_eff, supply_input_common, supply_input_mux}, 48'h18000);
        wr(16'h0a99);
        chk("off", {flex_pack_en_eff, block_voltage_port_sel, block_divider_sel, balance_switch_diag_alert_mask}, 48'h40007c00);
    endtask
    task t_addr;
        wr(16'hc0aa);
        @(posedge clk);
        reg_addr <= 8'h19;
        reg_wr <= 1'b1;
        reg_wdata <= 16'h0f99;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
        #1;
        chk("rd other", reg_rdata, 48'h0);
        @(posedge clk);
        reg_addr <= 8'h18;
        @(posedge clk);
        #1;
        chk("kept", reg_rdata, 48'hc0aa);
        chk("mux kept", {supply_input_common, supply_input_mux}, 48'h400);
    endtask
    task t_rerun;
        wr(16'hc0aa);
        chk("mux on", {supply_input_common, supply_input_mux}, 48'h400);
        @(posedge clk);
        reset <= 1'b1;
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
    endtask
    task sc(input [15:0] v, input a, input [15:0] e);
        wr(v);
        @(posedge clk);
        alternate_mux_select <= a;
        scan_sample_req <= 1'b1;
        @(posedge clk);
        scan_sample_req <= 1'b0;
        #1;
        n = 0;
        while (scan_sample_go !== 1'b1 && n < 4000) begin
            @(posedge clk);
            #1;
            n = n + 1;
        end
        chk("delay", n, e);
    endtask
    task results;
        if (mismatches == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge clk);
        reset <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
        t_cells;
        t_blocks;
        t_mismatch;
        t_addr;
        t_rerun;
        sc(16'he0aa, 1'b1, 16'hbb8);
        sc(16'ha0aa, 1'b1, 16'hbb8);
        sc(16'he0ff, 1'b1, 16'h0);
        sc(16'he0aa, 1'b0, 16'h0);
        sc(16'hc0aa, 1'b1, 16'h0);
        sc(16'he0a9, 1'b1, 16'h0);
        sc(16'h20aa, 1'b1, 16'h0);
        results;
    end
    initial begin
        #200000;
        mismatches = mismatches + 1;
        results;
    end
endmodule // ptcd_top_tb
bind ptcd_top ptcd_chk chk_u (
    .clk                            (clk),
    .reset                          (reset),
    .scan_sample_req                (scan_sample_req),
    .scan_settling                  (scan_settling),
    .scan_sample_go                 (scan_sample_go),
    .supply_input_mux               (supply_input_mux),
    .supply_input_common            (supply_input_common),
    .balance_switch_diag_alert_mask (balance_switch_diag_alert_mask),
    .block_divider_sel              (block_divider_sel),
    .block_voltage_port_sel         (block_voltage_port_sel),
    .flex_pack_en_eff               (flex_pack_en_eff),
    .top_channel_agree              (top_channel_agree)
);
